// >>> shared/tlsac_pkg.sv
// settings, register map and defaults for the tank level sampling and alarm core
package tlsac_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned TICK_S = 1;
	localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_S;
	localparam int unsigned NUM_ALARMS = 4;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_SAMPLE_SEL = 12'h004;
	localparam logic [11:0] OFS_PURGE_SEL = 12'h008;
	localparam logic [11:0] OFS_PURGE_DUR = 12'h00C;
	localparam logic [11:0] OFS_MAN_GRAV = 12'h010;
	localparam logic [11:0] OFS_FILTER = 12'h014;
	localparam logic [11:0] OFS_TIMEOUT = 12'h018;
	localparam logic [11:0] OFS_ALARM_CFG = 12'h01C;
	localparam logic [11:0] OFS_ACK = 12'h020;
	localparam logic [11:0] OFS_STATUS = 12'h024;
	localparam logic [11:0] OFS_ACT_GRAV = 12'h028;
	localparam logic [11:0] OFS_UNIT_SCALE = 12'h02C;
	localparam logic [11:0] OFS_SETPOINT = 12'h030;
	localparam logic [11:0] OFS_HYST = 12'h040;
	localparam int unsigned CTRL_AUTO_SAMPLE = 0;
	localparam int unsigned CTRL_GRAV_AUTO = 1;
	localparam int unsigned CTRL_ERASE = 2;
	localparam logic [7:0] PURGE_DUR_MIN = 8'h05;
	localparam logic [7:0] PURGE_DUR_MAX = 8'hB4;
	localparam logic [4:0] TIMEOUT_MAX = 5'h1E;
	localparam int unsigned SCALE_SHIFT = 8;
	localparam logic [2:0] SEL_OFF = 3'h0;
	typedef struct packed {
		logic auto_sample;
		logic gravity_auto;
		logic [2:0] sample_sel;
		logic [2:0] purge_sel;
		logic [7:0] purge_dur;
		logic [15:0] man_grav;
		logic [7:0] filter;
		logic [4:0] timeout;
		logic [3:0] lamp_en;
		logic [3:0] latch;
		logic [3:0] high_dir;
		logic [3:0][15:0] setpoint;
		logic [3:0][15:0] hyst;
	} tlsac_cfg_t;
	localparam tlsac_cfg_t CFG_DEFAULT = '{
		auto_sample: 1'b0, gravity_auto: 1'b0, sample_sel: 3'h0, purge_sel: 3'h7,
		purge_dur: 8'h05, man_grav: 16'h03E8, filter: 8'h00, timeout: 5'h00,
		lamp_en: 4'h0, latch: 4'h0, high_dir: 4'h3, setpoint: '0, hyst: '0};
	// cycle time list in seconds, index 0 means off
	function automatic logic [11:0] tlsac_interval_s(input logic [2:0] sel);
		case (sel)
			3'h1: tlsac_interval_s = 12'h00A;
			3'h2: tlsac_interval_s = 12'h01E;
			3'h3: tlsac_interval_s = 12'h03C;
			3'h4: tlsac_interval_s = 12'h12C;
			3'h5: tlsac_interval_s = 12'h258;
			3'h6: tlsac_interval_s = 12'h708;
			3'h7: tlsac_interval_s = 12'hE10;
			default: tlsac_interval_s = 12'h000;
		endcase
	endfunction
endpackage

// >>> logic/tlsac_core.sv
// sampling, purge, gravity filter and alarm core with apb registers
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module tlsac_core import tlsac_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] level_value,
	input wire logic gravity_valid,
	input wire logic [15:0] new_gravity_reading,
	input wire logic gravity_fault_pin,
	input wire logic ack_key_pin,
	output logic sample_start,
	output logic purge_on,
	output logic [3:0] alarm_active,
	output logic [3:0] alarm_lamp,
	output logic [15:0] active_gravity
);
	tlsac_cfg_t cfg;
	logic [31:0] tick_cnt;
	logic tick;
	logic [1:0] fault_sync;
	logic [1:0] ack_sync;
	logic ack_last;
	logic ack_press;
	logic [11:0] sample_cnt;
	logic [11:0] purge_cnt;
	logic [7:0] dur_cnt;
	logic [15:0] last_level;
	logic [15:0] stored_gravity_value;
	logic gravity_seen;
	logic [3:0] raw_cond;
	logic [3:0] held_cond;
	logic [3:0][5:0] pers_cnt;
	logic [3:0] trigger;
	logic [3:0] ack_bits;
	logic wr_en;
	logic rd_en;
	logic wr_ok;
	logic [31:0] next_rdata;
	logic next_err;
	logic [11:0] sample_ivl;
	logic [11:0] purge_ivl;
	logic [23:0] filt_sum;
	logic [15:0] next_gravity;
	logic grav_sel_now;

	// apb: one wait state, write acts at the edge pready is seen
	assign wr_en = psel & penable & pready & pwrite;
	assign rd_en = psel & penable & ~pready;

	function automatic logic [15:0] scale16(input logic [15:0] v, input logic [15:0] f);
		logic [31:0] p;
		p = 32'(v) * 32'(f);
		scale16 = p[SCALE_SHIFT +: 16];
	endfunction

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		wr_ok = 1'b1;
		case (paddr)
			OFS_CTRL: next_rdata = {30'h0, cfg.gravity_auto, cfg.auto_sample};
			OFS_SAMPLE_SEL: next_rdata = {29'h0, cfg.sample_sel};
			OFS_PURGE_SEL: next_rdata = {29'h0, cfg.purge_sel};
			OFS_PURGE_DUR: begin
				next_rdata = {24'h0, cfg.purge_dur};
				wr_ok = pwdata[7:0] >= PURGE_DUR_MIN && pwdata[7:0] <= PURGE_DUR_MAX
					&& pwdata[31:8] == 24'h0;
			end
			OFS_MAN_GRAV: next_rdata = {16'h0, cfg.man_grav};
			OFS_FILTER: next_rdata = {24'h0, cfg.filter};
			OFS_TIMEOUT: begin
				next_rdata = {27'h0, cfg.timeout};
				wr_ok = pwdata[4:0] <= TIMEOUT_MAX && pwdata[31:5] == 27'h0;
			end
			OFS_ALARM_CFG: next_rdata = {20'h0, cfg.high_dir, cfg.latch, cfg.lamp_en};
			OFS_ACK: next_rdata = 32'h0000_0000;
			OFS_STATUS: next_rdata = {20'h0, raw_cond, alarm_active, 1'b0, fault_sync[1],
				gravity_seen, purge_on};
			OFS_ACT_GRAV: next_rdata = {16'h0, active_gravity};
			OFS_UNIT_SCALE: next_rdata = 32'h0000_0000;
			default: begin
				if (paddr[11:4] == OFS_SETPOINT[11:4] && paddr[1:0] == 2'h0) begin
					next_rdata = {16'h0, cfg.setpoint[paddr[3:2]]};
				end else if (paddr[11:4] == OFS_HYST[11:4] && paddr[1:0] == 2'h0) begin
					next_rdata = {16'h0, cfg.hyst[paddr[3:2]]};
				end else begin
					next_err = 1'b1;
				end
			end
		endcase
		if (pwrite) begin
			next_rdata = 32'h0000_0000;
			next_err = next_err | ~wr_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= rd_en;
			prdata <= rd_en ? next_rdata : 32'h0000_0000;
			pslverr <= rd_en & next_err;
		end
	end

	// configuration store, erase restores defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= CFG_DEFAULT;
		end else if (wr_en && wr_ok) begin
			case (paddr)
				OFS_CTRL: begin
					if (pwdata[CTRL_ERASE]) begin
						cfg <= CFG_DEFAULT;
					end else begin
						cfg.auto_sample <= pwdata[CTRL_AUTO_SAMPLE];
						cfg.gravity_auto <= pwdata[CTRL_GRAV_AUTO];
					end
				end
				OFS_SAMPLE_SEL: cfg.sample_sel <= pwdata[2:0];
				OFS_PURGE_SEL: cfg.purge_sel <= pwdata[2:0];
				OFS_PURGE_DUR: cfg.purge_dur <= pwdata[7:0];
				OFS_MAN_GRAV: cfg.man_grav <= pwdata[15:0];
				OFS_FILTER: cfg.filter <= pwdata[7:0];
				OFS_TIMEOUT: cfg.timeout <= pwdata[4:0];
				OFS_ALARM_CFG: begin
					cfg.lamp_en <= pwdata[3:0];
					cfg.latch <= pwdata[7:4];
					cfg.high_dir <= pwdata[11:8];
				end
				OFS_UNIT_SCALE: begin
					for (int i = 0; i < NUM_ALARMS; i++) begin
						cfg.setpoint[i] <= scale16(cfg.setpoint[i], pwdata[15:0]);
						cfg.hyst[i] <= scale16(cfg.hyst[i], pwdata[15:0]);
					end
				end
				default: begin
					if (paddr[11:4] == OFS_SETPOINT[11:4]) begin
						cfg.setpoint[paddr[3:2]] <= pwdata[15:0];
					end else if (paddr[11:4] == OFS_HYST[11:4]) begin
						cfg.hyst[paddr[3:2]] <= pwdata[15:0];
					end
				end
			endcase
		end
	end

	assign ack_bits = (wr_en && paddr == OFS_ACK) ? pwdata[3:0] : 4'h0;

	// seconds tick from the system clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else begin
			tick <= tick_cnt == TICK_CYCLES - 1;
			tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h1;
		end
	end

	// pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_sync <= 2'h0;
			ack_sync <= 2'h0;
			ack_last <= 1'b0;
		end else begin
			fault_sync <= {fault_sync[0], gravity_fault_pin};
			ack_sync <= {ack_sync[0], ack_key_pin};
			ack_last <= ack_sync[1];
		end
	end
	assign ack_press = ack_sync[1] & ~ack_last;

	assign sample_ivl = tlsac_interval_s(cfg.sample_sel);
	assign purge_ivl = tlsac_interval_s(cfg.purge_sel);

	// sample scheduling, held off while purging
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_cnt <= 12'h000;
			sample_start <= 1'b0;
			last_level <= 16'h0000;
		end else begin
			sample_start <= 1'b0;
			if (tick) begin
				sample_cnt <= sample_cnt + 12'h1;
			end
			if (!purge_on) begin
				if (cfg.sample_sel != SEL_OFF && tick && sample_cnt + 12'h1 >= sample_ivl) begin
					sample_start <= 1'b1;
					sample_cnt <= 12'h000;
					last_level <= level_value;
				end else if (cfg.auto_sample && level_value != last_level) begin
					sample_start <= 1'b1;
					last_level <= level_value;
				end
			end
		end
	end

	// purge cycle and duration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			purge_cnt <= 12'h000;
			dur_cnt <= 8'h00;
			purge_on <= 1'b0;
		end else if (purge_on) begin
			if (tick) begin
				if (dur_cnt + 8'h1 >= cfg.purge_dur) begin
					purge_on <= 1'b0;
					dur_cnt <= 8'h00;
				end else begin
					dur_cnt <= dur_cnt + 8'h1;
				end
			end
		end else if (tick) begin
			if (cfg.purge_sel != SEL_OFF && purge_cnt + 12'h1 >= purge_ivl) begin
				purge_on <= 1'b1;
				purge_cnt <= 12'h000;
			end else begin
				purge_cnt <= purge_cnt + 12'h1;
			end
		end
	end

	// gravity filter and source choice
	assign filt_sum = 24'(stored_gravity_value) * 24'(cfg.filter) + 24'(new_gravity_reading);
	assign next_gravity = 16'(filt_sum / (24'(cfg.filter) + 24'h1));
	assign grav_sel_now = wr_en && wr_ok && paddr == OFS_CTRL && pwdata[CTRL_GRAV_AUTO]
		&& !pwdata[CTRL_ERASE] && !cfg.gravity_auto;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stored_gravity_value <= 16'h0000;
			gravity_seen <= 1'b0;
		end else if (grav_sel_now) begin
			gravity_seen <= 1'b0;
		end else if (gravity_valid && cfg.gravity_auto && !fault_sync[1]) begin
			stored_gravity_value <= gravity_seen ? next_gravity : new_gravity_reading;
			gravity_seen <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_gravity <= CFG_DEFAULT.man_grav;
		end else if (cfg.gravity_auto && gravity_seen && !fault_sync[1]) begin
			active_gravity <= stored_gravity_value;
		end else begin
			active_gravity <= cfg.man_grav;
		end
	end

	// alarm evaluation, one slice per alarm point
	for (genvar i = 0; i < NUM_ALARMS; i++) begin : g_alarm
		logic [16:0] lo_edge;
		logic [16:0] hi_edge;
		assign lo_edge = 17'(cfg.setpoint[i]) - 17'(cfg.hyst[i]);
		assign hi_edge = 17'(cfg.setpoint[i]) + 17'(cfg.hyst[i]);
		assign raw_cond[i] = cfg.high_dir[i] ? level_value >= cfg.setpoint[i]
			: level_value <= cfg.setpoint[i];
		assign held_cond[i] = cfg.high_dir[i]
			? (lo_edge[16] || 17'(level_value) > lo_edge)
			: (17'(level_value) < hi_edge);
		assign trigger[i] = raw_cond[i] && (cfg.timeout == 5'h00
			|| pers_cnt[i] > 6'(cfg.timeout));

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pers_cnt[i] <= 6'h00;
			end else if (!raw_cond[i]) begin
				pers_cnt[i] <= 6'h00;
			end else if (tick && pers_cnt[i] != 6'h3F) begin
				pers_cnt[i] <= pers_cnt[i] + 6'h1;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				alarm_active[i] <= 1'b0;
			end else if (trigger[i]) begin
				alarm_active[i] <= 1'b1;
			end else if (alarm_active[i] && !held_cond[i]) begin
				if (!cfg.latch[i] || ack_press || ack_bits[i]) begin
					alarm_active[i] <= 1'b0;
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				alarm_lamp[i] <= 1'b0;
			end else begin
				alarm_lamp[i] <= alarm_active[i] & cfg.lamp_en[i];
			end
		end
	end

	// checks
	a_purge_range: assert property (@(posedge pclk) disable iff (!presetn)
		cfg.purge_dur >= PURGE_DUR_MIN && cfg.purge_dur <= PURGE_DUR_MAX)
		else $error("purge duration out of range");
	a_purge_ends: assert property (@(posedge pclk) disable iff (!presetn)
		purge_on && tick && dur_cnt + 8'h1 >= cfg.purge_dur |=> !purge_on)
		else $error("purge did not end after duration");
	a_purge_start: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(purge_on) |-> $past(tick) && $past(purge_cnt) + 12'h1 >= $past(purge_ivl))
		else $error("purge started early");
	a_auto_sample: assert property (@(posedge pclk) disable iff (!presetn)
		cfg.auto_sample && !purge_on && level_value != last_level |=> sample_start)
		else $error("level change gave no sample");
	a_timeout_max: assert property (@(posedge pclk) disable iff (!presetn)
		cfg.timeout <= TIMEOUT_MAX)
		else $error("timeout above limit");
	a_grav_fallback: assert property (@(posedge pclk) disable iff (!presetn)
		fault_sync[1] ##1 fault_sync[1] |=> active_gravity == $past(cfg.man_grav))
		else $error("fault did not select manual gravity");
	a_grav_wait: assert property (@(posedge pclk) disable iff (!presetn)
		!gravity_seen ##1 !gravity_seen |-> active_gravity == $past(cfg.man_grav))
		else $error("gravity used before first reading");
	a_filter_zero: assert property (@(posedge pclk) disable iff (!presetn)
		gravity_valid && cfg.gravity_auto && !fault_sync[1] && !grav_sel_now
		&& cfg.filter == 8'h00 |=> stored_gravity_value == $past(new_gravity_reading))
		else $error("zero filter did not replace value");
	a_lamp_gate: assert property (@(posedge pclk) disable iff (!presetn)
		alarm_lamp != 4'h0 |-> ($past(cfg.lamp_en) & alarm_lamp) == alarm_lamp)
		else $error("lamp lit for disabled point");
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		alarm_active[0] && cfg.latch[0] && !ack_press && ack_bits[0] == 1'b0
		|=> alarm_active[0])
		else $error("latched alarm cleared without ack");
	a_ack_held: assert property (@(posedge pclk) disable iff (!presetn)
		alarm_active[0] && held_cond[0] |=> alarm_active[0])
		else $error("alarm cleared inside hysteresis");
	a_persist: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(alarm_active[0]) && $past(cfg.timeout) != 5'h00
		|-> $past(pers_cnt[0]) > 6'($past(cfg.timeout)))
		else $error("alarm before timeout");
	c_purge_done: cover property (@(posedge pclk) disable iff (!presetn) $fell(purge_on));
	c_sample: cover property (@(posedge pclk) disable iff (!presetn) sample_start);
	c_latched_ack: cover property (@(posedge pclk) disable iff (!presetn)
		cfg.latch[0] && $fell(alarm_active[0]));
	c_filtered: cover property (@(posedge pclk) disable iff (!presetn)
		gravity_valid && gravity_seen && cfg.filter != 8'h00);
endmodule

// >>> tb/tlsac_plant.sv
// plant model: level source, gravity probe answering samples, operator keys
`timescale 1ns/1ps
module tlsac_plant (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sample_start,
	input wire logic [15:0] level_set,
	input wire logic [15:0] grav_set,
	input wire logic fault_set,
	input wire logic ack_set,
	output logic [15:0] level_value,
	output logic gravity_valid,
	output logic [15:0] new_gravity_reading,
	output logic gravity_fault_pin,
	output logic ack_key_pin
);
	logic [2:0] dly;
	assign level_value = level_set;
	assign gravity_fault_pin = fault_set;
	assign ack_key_pin = ack_set;
	// probe answers a few cycles after each sample start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly <= 3'h0;
			gravity_valid <= 1'b0;
			new_gravity_reading <= 16'h0000;
		end else begin
			gravity_valid <= (dly == 3'h1);
			if (sample_start) begin
				dly <= 3'h4;
			end else if (dly != 3'h0) begin
				dly <= dly - 3'h1;
			end
			// reading is only meaningful with the valid pulse
			new_gravity_reading <= (dly == 3'h1) ? grav_set : ~new_gravity_reading;
		end
	end
endmodule

// >>> tb/tlsac_core_bench.sv
// self-checking bench for the sampling, purge, gravity and alarm core
`timescale 1ns/1ps
module tlsac_core_bench import tlsac_pkg::*; ;
	localparam int TK = 10;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [15:0] level_value, new_gravity_reading, active_gravity, level_set, grav_set;
	logic gravity_valid, gravity_fault_pin, ack_key_pin, sample_start, purge_on;
	logic fault_set, ack_set;
	logic [3:0] alarm_active, alarm_lamp;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n_samp = 0;
	int k, g;
	int rq[$];
	tlsac_core #(.TICK_CYCLES(TK)) u_tlsac_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .level_value(level_value),
		.gravity_valid(gravity_valid), .new_gravity_reading(new_gravity_reading),
		.gravity_fault_pin(gravity_fault_pin), .ack_key_pin(ack_key_pin),
		.sample_start(sample_start), .purge_on(purge_on), .alarm_active(alarm_active),
		.alarm_lamp(alarm_lamp), .active_gravity(active_gravity));
	tlsac_plant u_tlsac_plant (.pclk(pclk), .presetn(presetn), .sample_start(sample_start),
		.level_set(level_set), .grav_set(grav_set), .fault_set(fault_set), .ack_set(ack_set),
		.level_value(level_value), .gravity_valid(gravity_valid),
		.new_gravity_reading(new_gravity_reading), .gravity_fault_pin(gravity_fault_pin),
		.ack_key_pin(ack_key_pin));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction
	task conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_errors++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task sample(input logic [15:0] lv);
		int s0;
		s0 = n_samp;
		seed = xs(seed);
		grav_set <= 16'(500 + seed % 1000);
		rq.push_back(500 + seed % 1000);
		level_set <= lv;
		repeat (12) @(posedge pclk);
		chk("sample", n_samp - s0, 1);
	endtask
	task ack();
		ack_set <= 1'b1;
		repeat (6) @(posedge pclk);
		ack_set <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	task lvl(input logic [15:0] lv, input int n);
		level_set <= lv;
		repeat (n) @(posedge pclk);
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (sample_start === 1'b1) begin
			n_samp <= n_samp + 1;
		end
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			conclude();
		end
	end
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		level_set = 16'h01F4;
		grav_set = 16'h03E8;
		fault_set = 1'b0;
		ack_set = 1'b0;
		seed = 32'd83547;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFS_PURGE_DUR, 0);
		chk("purge_dur", rd, 5);
		apb(0, OFS_FILTER, 0);
		chk("filter", rd, 0);
		apb(0, OFS_TIMEOUT, 0);
		chk("timeout", rd, 0);
		apb(0, OFS_MAN_GRAV, 0);
		chk("man_grav", rd, 1000);
		apb(0, OFS_PURGE_SEL, 0);
		chk("purge_sel", rd, 7);
		chk("act_grav", active_gravity, 1000);
		$display("test defaults done");
		apb(1, OFS_PURGE_DUR, 4);
		chk("dur_low", err, 1);
		apb(1, OFS_PURGE_DUR, 181);
		chk("dur_high", err, 1);
		apb(1, OFS_PURGE_DUR, 180);
		apb(0, OFS_PURGE_DUR, 0);
		chk("dur_max", rd, 180);
		apb(1, OFS_TIMEOUT, 31);
		chk("tmo_high", err, 1);
		apb(0, OFS_TIMEOUT, 0);
		chk("tmo_kept", rd, 0);
		apb(0, 12'h100, 0);
		chk("unmapped", err, 1);
		$display("test limits done");
		apb(1, OFS_PURGE_DUR, 5);
		apb(1, OFS_PURGE_SEL, 1);
		for (int p = 0; p < 2; p++) begin
			k = 0;
			while (purge_on !== 1'b1 && k < 200) begin
				@(posedge pclk);
				k++;
			end
			chk("purge_start", purge_on, 1);
			k = 0;
			while (purge_on === 1'b1 && k < 4000) begin
				@(posedge pclk);
				k++;
			end
			chk("purge_len", k, 5 * TK);
		end
		apb(1, OFS_PURGE_SEL, 0);
		$display("test purge done");
		apb(1, OFS_CTRL, 3);
		chk("grav_new_auto", active_gravity, 1000);
		sample(16'h0258);
		g = rq.pop_front();
		chk("grav_first", active_gravity, g);
		apb(1, OFS_FILTER, 3);
		sample(16'h02BC);
		g = (g * 3 + rq.pop_front()) / 4;
		chk("grav_filt", active_gravity, g);
		apb(0, OFS_ACT_GRAV, 0);
		chk("act_grav_rd", rd, g);
		fault_set <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("grav_fault", active_gravity, 1000);
		apb(0, OFS_STATUS, 0);
		chk("stat_fault", rd[2:0], 3'h6);
		fault_set <= 1'b0;
		apb(1, OFS_SAMPLE_SEL, 1);
		k = n_samp;
		repeat (130) @(posedge pclk);
		chk("interval", (n_samp - k) >= 1, 1);
		apb(1, OFS_SAMPLE_SEL, 0);
		$display("test gravity done");
		apb(1, OFS_SETPOINT, 1000);
		apb(1, OFS_HYST, 100);
		apb(1, OFS_ALARM_CFG, 32'h0311);
		lvl(16'd1000, 4);
		chk("alarm_on", alarm_active, 4'h3);
		chk("lamp", alarm_lamp, 4'h1);
		lvl(16'd950, 2);
		ack();
		chk("ack_in_band", alarm_active[0], 1);
		lvl(16'd800, 6);
		chk("latched", alarm_active[0], 1);
		ack();
		chk("ack_clear", alarm_active[0], 0);
		lvl(16'd1000, 4);
		lvl(16'd800, 4);
		chk("relatched", alarm_active[0], 1);
		apb(1, OFS_ACK, 32'h1);
		lvl(16'd800, 2);
		chk("reg_ack_clear", alarm_active[0], 0);
		apb(1, OFS_ALARM_CFG, 32'h0301);
		lvl(16'd1000, 4);
		chk("re_on", alarm_active[0], 1);
		lvl(16'd950, 4);
		chk("in_band", alarm_active[0], 1);
		lvl(16'd900, 4);
		chk("band_clear", alarm_active[0], 0);
		apb(1, OFS_TIMEOUT, 3);
		lvl(16'd1000, 22);
		chk("tmo_wait", alarm_active[0], 0);
		repeat (40) @(posedge pclk);
		chk("tmo_fire", alarm_active[0], 1);
		$display("test alarms done");
		apb(1, OFS_UNIT_SCALE, 32'h200);
		apb(0, OFS_SETPOINT, 0);
		chk("sp_scaled", rd, 2000);
		apb(0, OFS_HYST, 0);
		chk("hy_scaled", rd, 200);
		$display("test units done");
		apb(1, OFS_PURGE_DUR, 100);
		apb(1, OFS_CTRL, 32'h4);
		apb(0, OFS_PURGE_DUR, 0);
		chk("erase_dur", rd, 5);
		apb(0, OFS_TIMEOUT, 0);
		chk("erase_tmo", rd, 0);
		$display("test erase done");
		conclude();
	end
endmodule
